// *** logic/vpan_pkg.sv ***
// vpan_pkg: constants for the emulated auto-negotiation block.
// assumes a word-wide register port with one-cycle read latency.
package vpan_pkg;
  localparam logic [7:0] VPAN_CTRL_OFS = 8'h00;
  localparam logic [7:0] VPAN_STAT_OFS = 8'h04;
  localparam logic [7:0] VPAN_ADV_OFS = 8'h10;
  localparam logic [7:0] VPAN_LPA_OFS = 8'h14;
  localparam logic [7:0] VPAN_EXP_OFS = 8'h18;
  localparam logic [7:0] VPAN_MFC_OFS = 8'h20;
  localparam logic [7:0] VPAN_CHIPRST_OFS = 8'h24;
  localparam int VPAN_CTRL_RST_BIT = 15;
  localparam int VPAN_CTRL_SPEED_BIT = 13;
  localparam int VPAN_CTRL_AN_BIT = 12;
  localparam int VPAN_CTRL_RESTART_BIT = 9;
  localparam int VPAN_CTRL_DUPLEX_BIT = 8;
  localparam int VPAN_STAT_DONE_BIT = 5;
  localparam int VPAN_EXP_PAGE_BIT = 1;
  localparam int VPAN_EXP_ABLE_BIT = 0;
  localparam int VPAN_ABIL_LSB = 5;
  localparam int VPAN_PAUSE_LSB = 10;
  localparam logic [15:0] VPAN_CTRL_RST_VAL = 16'h3100;
  localparam logic [15:0] VPAN_STAT_RST_VAL = 16'h7809;
  localparam logic [15:0] VPAN_ADV_RST_VAL = 16'h01e1;
  localparam logic [15:0] VPAN_SELECTOR = 16'h0001;
  localparam logic [15:0] VPAN_ADV_WMASK = 16'h0de0;
  localparam logic [3:0] VPAN_ABIL_10H = 4'h1;
  localparam logic [3:0] VPAN_ABIL_10F = 4'h2;
  localparam logic [3:0] VPAN_ABIL_100H = 4'h4;
  localparam logic [3:0] VPAN_ABIL_100F = 4'h8;
  localparam int VPAN_MFC_SEL_BIT = 4;
  localparam int VPAN_MFC_DUP_BIT = 3;
  localparam int VPAN_MFC_RX_BIT = 1;
  localparam int VPAN_MFC_TX_BIT = 0;
  localparam int VPAN_CHIPRST_DIG_BIT = 0;
  localparam int VPAN_CHIPRST_PHY_BIT = 1;
  localparam int VPAN_SOFTRST_US = 102;
  localparam int VPAN_CLK_MHZ = 200;
  localparam int VPAN_SOFTRST_CYC = VPAN_SOFTRST_US * VPAN_CLK_MHZ;
  typedef enum logic [1:0] {
    VPAN_IDLE = 2'b00,
    VPAN_DONE_ST = 2'b01,
    VPAN_PAGE_ST = 2'b11,
    VPAN_RES_ST = 2'b10
  } vpan_state_t;
endpackage : vpan_pkg

// *** logic/vpan_autoneg.sv ***
// vpan_autoneg: emulated auto-negotiation of one virtual phy.
// assumes strobes from a single-cycle register master and static straps.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module vpan_autoneg
  import vpan_pkg::*;
#(
  parameter int SOFTRST_CYC = VPAN_SOFTRST_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic mii_mgmt_wr,
  input wire logic mii_mgmt_rd,
  output logic mii_mgmt_ack,
  input wire logic mac_mode,
  input wire logic loader_reload,
  input wire logic loader_strap_upd,
  input wire logic duplex_strap,
  input wire logic speed_strap,
  output logic fabric_full_duplex,
  output logic fabric_speed_100,
  output logic fabric_tx_pause,
  output logic fabric_rx_pause,
  output logic neg_complete
);
  // ==========================================================
  // registers
  logic [15:0] ctrl_q, adv_q, adv_used_q, lpa_q, mfc_q;
  logic done_q, page_q, able_q, dig_q;
  logic phy_rst_q;
  logic [15:0] rst_cnt_q;
  logic dup_q, spd_q, txp_q, rxp_q;
  vpan_state_t st_q;
  logic wr_ctrl, wr_adv, wr_mfc, wr_chip, restart;
  logic [15:0] rdata_d;
  logic neg_en;

  assign wr_ctrl = reg_wr && reg_addr == VPAN_CTRL_OFS;
  assign wr_adv = reg_wr && reg_addr == VPAN_ADV_OFS;
  assign wr_mfc = reg_wr && reg_addr == VPAN_MFC_OFS;
  assign wr_chip = reg_wr && reg_addr == VPAN_CHIPRST_OFS;
  assign neg_en = ctrl_q[VPAN_CTRL_AN_BIT];

  // ==========================================================
  // restart events
  always_comb begin
    // strap levels are not restart events; only the loader's update is
    restart = loader_reload || loader_strap_upd;
    if (wr_ctrl && (reg_wdata[VPAN_CTRL_RESTART_BIT] ||
        reg_wdata[VPAN_CTRL_RST_BIT])) begin
      restart = 1'b1;
    end
    if (wr_chip && reg_wdata[VPAN_CHIPRST_PHY_BIT]) begin
      restart = 1'b1;
    end
    if (dig_q || phy_rst_q) begin
      restart = 1'b1;
    end
  end

  // soft reset bit self clears after a fixed time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phy_rst_q <= 1'b0;
      rst_cnt_q <= 16'h0000;
    end else if (wr_chip && reg_wdata[VPAN_CHIPRST_PHY_BIT]) begin
      phy_rst_q <= 1'b1;
      rst_cnt_q <= 16'(SOFTRST_CYC);
    end else if (rst_cnt_q != 16'h0000) begin
      rst_cnt_q <= rst_cnt_q - 16'h0001;
      phy_rst_q <= rst_cnt_q != 16'h0001;
    end else begin
      phy_rst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dig_q <= 1'b0;
    end else begin
      dig_q <= wr_chip && reg_wdata[VPAN_CHIPRST_DIG_BIT];
    end
  end

  // ==========================================================
  // control register; restart and reset bits self clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= VPAN_CTRL_RST_VAL;
    end else if (wr_ctrl && reg_wdata[VPAN_CTRL_RST_BIT]) begin
      ctrl_q <= VPAN_CTRL_RST_VAL;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata & ~(16'h0001 << VPAN_CTRL_RESTART_BIT) &
                ~(16'h0001 << VPAN_CTRL_RST_BIT);
    end
  end

  // advertisement: abilities and pause only, no np/rf/t4
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adv_q <= VPAN_ADV_RST_VAL;
    end else if (wr_ctrl && reg_wdata[VPAN_CTRL_RST_BIT]) begin
      adv_q <= VPAN_ADV_RST_VAL;
    end else if (wr_adv) begin
      adv_q <= (reg_wdata & VPAN_ADV_WMASK) | VPAN_SELECTOR;
    end
  end

  // manual flow control; never touches adv_q
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mfc_q <= 16'h0000;
    end else if (wr_mfc) begin
      mfc_q <= reg_wdata & 16'h001f;
    end
  end

  // ==========================================================
  // negotiation sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= VPAN_DONE_ST;
    end else if (restart) begin
      st_q <= VPAN_DONE_ST;
    end else begin
      case (st_q)
        VPAN_DONE_ST: st_q <= neg_en ? VPAN_PAGE_ST : VPAN_DONE_ST;
        VPAN_PAGE_ST: st_q <= VPAN_RES_ST;
        VPAN_RES_ST: st_q <= VPAN_IDLE;
        VPAN_IDLE: st_q <= VPAN_IDLE;
        default: st_q <= VPAN_IDLE;
      endcase
    end
  end

  logic [3:0] lp_abil, common;
  assign lp_abil = {speed_strap & duplex_strap, speed_strap,
                    duplex_strap, 1'b1};
  assign common = adv_used_q[VPAN_ABIL_LSB +: 4] & lp_abil;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      page_q <= 1'b0;
      able_q <= 1'b0;
      adv_used_q <= VPAN_ADV_RST_VAL;
      lpa_q <= 16'h0000;
    end else if (restart) begin
      done_q <= 1'b0;
      page_q <= 1'b0;
    end else begin
      case (st_q)
        VPAN_DONE_ST: begin
          if (neg_en) begin
            done_q <= 1'b1;
            adv_used_q <= adv_q;
          end
        end
        VPAN_PAGE_ST: page_q <= 1'b1;
        VPAN_RES_ST: begin
          able_q <= common != 4'h0;
          if (common != 4'h0) begin
            lpa_q <= {4'h0, adv_used_q[VPAN_PAUSE_LSB +: 2], 1'b0,
                      lp_abil, 5'(VPAN_SELECTOR)};
          end else begin
            lpa_q <= {4'h0, adv_used_q[VPAN_PAUSE_LSB +: 2], 1'b0,
                      speed_strap ? VPAN_ABIL_100H : VPAN_ABIL_10H,
                      5'(VPAN_SELECTOR)};
          end
        end
        VPAN_IDLE: done_q <= done_q;
        default: done_q <= done_q;
      endcase
    end
  end

  // ==========================================================
  // resolved operating point
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dup_q <= 1'b1;
      spd_q <= 1'b1;
    end else if (!neg_en) begin
      dup_q <= ctrl_q[VPAN_CTRL_DUPLEX_BIT];
      spd_q <= ctrl_q[VPAN_CTRL_SPEED_BIT];
    end else if (st_q == VPAN_RES_ST && !restart) begin
      // control speed/duplex bits are not consulted here
      if (common[3]) begin
        {spd_q, dup_q} <= 2'b11;
      end else if (common[2]) begin
        {spd_q, dup_q} <= 2'b10;
      end else if (common[1]) begin
        {spd_q, dup_q} <= 2'b01;
      end else if (common[0]) begin
        {spd_q, dup_q} <= 2'b00;
      end else begin
        {spd_q, dup_q} <= {speed_strap, 1'b0};
      end
    end
  end

  // pause: partner mirrors; tx on either advertised pause bit, rx on the symmetric bit, full duplex only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txp_q <= 1'b0;
      rxp_q <= 1'b0;
    end else if (!neg_en || mfc_q[VPAN_MFC_SEL_BIT]) begin
      txp_q <= mfc_q[VPAN_MFC_TX_BIT];
      rxp_q <= mfc_q[VPAN_MFC_RX_BIT];
    end else begin
      txp_q <= dup_q && (adv_used_q[VPAN_PAUSE_LSB] ||
               adv_used_q[VPAN_PAUSE_LSB + 1]);
      rxp_q <= dup_q && adv_used_q[VPAN_PAUSE_LSB];
    end
  end

  // ==========================================================
  // read port
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      VPAN_CTRL_OFS: rdata_d = ctrl_q;
      VPAN_STAT_OFS: rdata_d = VPAN_STAT_RST_VAL |
                               (16'(done_q) << VPAN_STAT_DONE_BIT);
      VPAN_ADV_OFS: rdata_d = adv_q;
      VPAN_LPA_OFS: rdata_d = lpa_q;
      VPAN_EXP_OFS: rdata_d = (16'(page_q) << VPAN_EXP_PAGE_BIT) |
                              16'(able_q);
      VPAN_MFC_OFS: rdata_d = {11'h000, mfc_q[VPAN_MFC_SEL_BIT], dup_q,
                               1'b0, rxp_q, txp_q};
      VPAN_CHIPRST_OFS: rdata_d = 16'(phy_rst_q) << VPAN_CHIPRST_PHY_BIT;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 16'h0000;
    end
  end

  // mii management answers only outside mac modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mii_mgmt_ack <= 1'b0;
    end else begin
      mii_mgmt_ack <= (mii_mgmt_rd || mii_mgmt_wr) && !mac_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fabric_full_duplex <= 1'b1;
      fabric_speed_100 <= 1'b1;
      fabric_tx_pause <= 1'b0;
      fabric_rx_pause <= 1'b0;
      neg_complete <= 1'b0;
    end else begin
      fabric_full_duplex <= dup_q;
      fabric_speed_100 <= spd_q;
      fabric_tx_pause <= txp_q;
      fabric_rx_pause <= rxp_q;
      neg_complete <= done_q && page_q;
    end
  end

  // ==========================================================
  // checks
  property p_seq_order;
    @(posedge clk) disable iff (!rst_n)
      $rose(page_q) |-> done_q;
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("page received before complete");

  property p_restart_clear;
    @(posedge clk) disable iff (!rst_n)
      restart |=> !done_q && !page_q;
  endproperty
  a_restart_clear: assert property (p_restart_clear)
    else $error("flags not cleared on restart");

  property p_finish;
    @(posedge clk) disable iff (!rst_n)
      (restart && neg_en) ##1 (!restart && neg_en)[*4] |-> st_q == VPAN_IDLE;
  endproperty
  a_finish: assert property (p_finish)
    else $error("negotiation did not finish");

  property p_no_neg_off;
    @(posedge clk) disable iff (!rst_n)
      !neg_en && !restart && st_q == VPAN_DONE_ST |=> !done_q;
  endproperty
  a_no_neg_off: assert property (p_no_neg_off)
    else $error("negotiation ran while disabled");

  property p_forced;
    @(posedge clk) disable iff (!rst_n)
      !neg_en |=> dup_q == $past(ctrl_q[VPAN_CTRL_DUPLEX_BIT]) &&
                  spd_q == $past(ctrl_q[VPAN_CTRL_SPEED_BIT]);
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced speed or duplex not applied");

  property p_parallel;
    @(posedge clk) disable iff (!rst_n)
      st_q == VPAN_RES_ST && !restart && neg_en && common == 4'h0 |=>
        !able_q && !dup_q && $onehot(lpa_q[VPAN_ABIL_LSB +: 4]);
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("parallel detect result wrong");

  property p_hcd;
    @(posedge clk) disable iff (!rst_n)
      st_q == VPAN_RES_ST && !restart && neg_en && common[3] |=>
        spd_q && dup_q && able_q;
  endproperty
  a_hcd: assert property (p_hcd)
    else $error("highest common ability not chosen");

  property p_adv_hold;
    @(posedge clk) disable iff (!rst_n)
      st_q == VPAN_IDLE && !restart |=> $stable(adv_used_q);
  endproperty
  a_adv_hold: assert property (p_adv_hold)
    else $error("advertisement applied after completion");

  property p_mii;
    @(posedge clk) disable iff (!rst_n)
      mac_mode |=> !mii_mgmt_ack;
  endproperty
  a_mii: assert property (p_mii)
    else $error("mii management answered in mac mode");

  property p_mfc_keep;
    @(posedge clk) disable iff (!rst_n)
      wr_mfc |=> $stable(adv_q);
  endproperty
  a_mfc_keep: assert property (p_mfc_keep)
    else $error("manual flow write changed advertisement");

  property p_result_order;
    @(posedge clk) disable iff (!rst_n)
      st_q == VPAN_RES_ST && !restart |-> done_q && page_q;
  endproperty
  a_result_order: assert property (p_result_order)
    else $error("result stored before complete and page");

  property p_no_extras;
    @(posedge clk) disable iff (!rst_n)
      ((adv_q | lpa_q) & ~(VPAN_ADV_WMASK | VPAN_SELECTOR)) == 16'h0000;
  endproperty
  a_no_extras: assert property (p_no_extras)
    else $error("next page, remote fault or t4 offered");

  property p_mirror;
    @(posedge clk) disable iff (!rst_n)
      st_q == VPAN_RES_ST && !restart |=>
        lpa_q[VPAN_PAUSE_LSB +: 2] == adv_used_q[VPAN_PAUSE_LSB +: 2];
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("partner pause does not mirror advertisement");

  property p_success;
    @(posedge clk) disable iff (!rst_n)
      st_q == VPAN_RES_ST && !restart && common != 4'h0 |=>
        able_q && lpa_q[VPAN_ABIL_LSB +: 4] == $past(lp_abil);
  endproperty
  a_success: assert property (p_success)
    else $error("partner abilities not loaded on success");
endmodule : vpan_autoneg
`default_nettype wire

// *** verification/vpan_mac_model.sv ***
// vpan_mac_model: mac driver side of the register port of one virtual phy.
// assumes the block answers a read in the cycle after the strobe, no waits.
`timescale 1ns/1ps
`default_nettype none
module vpan_mac_model (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ==========================================================
  // single-cycle write and read strobes
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released data must not look like the last word
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : vpan_mac_model
`default_nettype wire

// *** verification/vpan_autoneg_tb.sv ***
// vpan_autoneg_tb: self-checking bench of the emulated negotiation block.
// assumes vpan_pkg and the mac model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
  end
module vpan_autoneg_tb;
  import vpan_pkg::*;
  logic clk, rst_n, mac_mode, duplex_strap, speed_strap;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, mii_mgmt_ack, neg_complete;
  logic fabric_full_duplex, fabric_speed_100;
  logic fabric_tx_pause, fabric_rx_pause;
  logic [3:0] ev;
  logic mii_mgmt_wr, mii_mgmt_rd, loader_reload, loader_strap_upd;
  int fails, cmp_count;
  assign {mii_mgmt_wr, mii_mgmt_rd, loader_strap_upd, loader_reload} = ev;

  vpan_autoneg #(.SOFTRST_CYC(8)) u_vpan_autoneg (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mii_mgmt_wr(mii_mgmt_wr),
    .mii_mgmt_rd(mii_mgmt_rd), .mii_mgmt_ack(mii_mgmt_ack),
    .mac_mode(mac_mode), .loader_reload(loader_reload),
    .loader_strap_upd(loader_strap_upd), .duplex_strap(duplex_strap),
    .speed_strap(speed_strap), .fabric_full_duplex(fabric_full_duplex),
    .fabric_speed_100(fabric_speed_100), .fabric_tx_pause(fabric_tx_pause),
    .fabric_rx_pause(fabric_rx_pause), .neg_complete(neg_complete));

  vpan_mac_model u_vpan_mac_model (.clk(clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));

  // ==========================================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [1:0] best(input logic [3:0] c);
    if (c[3]) return 2'b11;
    if (c[2]) return 2'b01;
    if (c[1]) return 2'b10;
    return 2'b00;
  endfunction : best

  task automatic chk_link(input logic [1:0] e);
    `CHK("full", e[1], fabric_full_duplex)
    `CHK("spd", e[0], fabric_speed_100)
  endtask : chk_link

  // write advertisement, restart with control speed/duplex cleared
  task automatic neg(input logic [15:0] adv);
    u_vpan_mac_model.wr(VPAN_ADV_OFS, adv);
    u_vpan_mac_model.wr(VPAN_CTRL_OFS, 16'h1200);
    repeat (8) @(posedge clk);
    #1;
  endtask : neg

  task automatic kick(input int k);
    @(posedge clk);
    ev <= 4'h1 << k;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask : kick

  task automatic wait_nc(input logic v, input int lim);
    int n;
    n = 0;
    while (neg_complete !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("neg_complete", v, neg_complete)
  endtask : wait_nc

  // ==========================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    mac_mode = 1'b0;
    ev = 4'h0;
    duplex_strap = 1'b1;
    speed_strap = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    u_vpan_mac_model.rd(VPAN_ADV_OFS, d);
    `CHK("adv", VPAN_ADV_RST_VAL, d)
    u_vpan_mac_model.rd(VPAN_STAT_OFS, d);
    `CHK("done", 1'b1, d[VPAN_STAT_DONE_BIT])
    u_vpan_mac_model.rd(VPAN_EXP_OFS, d);
    `CHK("exp", 2'b11, d[1:0])
    u_vpan_mac_model.rd(VPAN_LPA_OFS, d);
    `CHK("lpa", 4'hf, d[8:5])
    `CHK("lpa np", 16'h0000, d & 16'ha200)
    chk_link(2'b11);
    $display("test reset done");
    for (int c = 1; c < 16; c++) begin
      neg((16'(c) << VPAN_ABIL_LSB) | VPAN_SELECTOR);
      chk_link(best(4'(c)));
    end
    u_vpan_mac_model.wr(VPAN_ADV_OFS, 16'h0021);
    repeat (8) @(posedge clk);
    #1;
    chk_link(2'b11);
    neg(16'h0021);
    chk_link(2'b00);
    $display("test priority done");
    u_vpan_mac_model.wr(VPAN_CTRL_OFS, 16'h0300);
    repeat (4) @(posedge clk);
    #1;
    chk_link(2'b10);
    `CHK("nc off", 1'b0, neg_complete)
    u_vpan_mac_model.rd(VPAN_STAT_OFS, d);
    `CHK("done off", 1'b0, d[VPAN_STAT_DONE_BIT])
    u_vpan_mac_model.wr(VPAN_CTRL_OFS, 16'h2000);
    repeat (4) @(posedge clk);
    #1;
    chk_link(2'b01);
    $display("test forced done");
    for (int p = 0; p < 4; p++) begin
      neg(16'h01e1 | (16'(p) << VPAN_PAUSE_LSB));
      `CHK("tx", p != 0, fabric_tx_pause)
      `CHK("rx", p[0], fabric_rx_pause)
      u_vpan_mac_model.rd(VPAN_LPA_OFS, d);
      `CHK("lpa pause", 2'(p), d[11:10])
    end
    u_vpan_mac_model.wr(VPAN_MFC_OFS, 16'h0012);
    repeat (4) @(posedge clk);
    #1;
    `CHK("tx", 1'b0, fabric_tx_pause)
    `CHK("rx", 1'b1, fabric_rx_pause)
    u_vpan_mac_model.rd(VPAN_MFC_OFS, d);
    `CHK("mfc", 3'b110, {d[3], d[1:0]})
    u_vpan_mac_model.rd(VPAN_ADV_OFS, d);
    `CHK("adv pause", 2'b11, d[11:10])
    u_vpan_mac_model.wr(VPAN_MFC_OFS, 16'h0000);
    repeat (4) @(posedge clk);
    #1;
    `CHK("tx", 1'b1, fabric_tx_pause)
    $display("test pause done");
    @(posedge clk) duplex_strap <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    `CHK("nc", 1'b1, neg_complete)
    chk_link(2'b11);
    neg(16'h0041);
    chk_link(2'b01);
    u_vpan_mac_model.rd(VPAN_EXP_OFS, d);
    `CHK("able", 1'b0, d[VPAN_EXP_ABLE_BIT])
    u_vpan_mac_model.rd(VPAN_LPA_OFS, d);
    `CHK("lpa", 4'h4, d[8:5])
    @(posedge clk) speed_strap <= 1'b0;
    neg(16'h0041);
    chk_link(2'b00);
    u_vpan_mac_model.rd(VPAN_LPA_OFS, d);
    `CHK("lpa", 4'h1, d[8:5])
    neg(16'h0021);
    u_vpan_mac_model.rd(VPAN_EXP_OFS, d);
    `CHK("able", 1'b1, d[VPAN_EXP_ABLE_BIT])
    @(posedge clk);
    duplex_strap <= 1'b1;
    speed_strap <= 1'b1;
    $display("test parallel done");
    for (int k = 0; k < 5; k++) begin
      u_vpan_mac_model.wr(VPAN_ADV_OFS, (16'h0020 << k) | VPAN_SELECTOR);
      case (k)
        0, 1: kick(k);
        2: u_vpan_mac_model.wr(VPAN_CHIPRST_OFS, 16'h0002);
        3: u_vpan_mac_model.wr(VPAN_CHIPRST_OFS, 16'h0001);
        default: u_vpan_mac_model.wr(VPAN_CTRL_OFS, 16'h9000);
      endcase
      wait_nc(1'b0, 12);
      wait_nc(1'b1, 40);
      // fabric outputs follow neg_complete by one cycle
      repeat (2) @(posedge clk);
      #1;
      chk_link(best(k < 4 ? 4'h1 << k : 4'hf));
    end
    $display("test restart done");
    @(posedge clk) mac_mode <= 1'b1;
    kick(2);
    `CHK("ack", 1'b0, mii_mgmt_ack)
    kick(3);
    `CHK("ack", 1'b0, mii_mgmt_ack)
    @(posedge clk) mac_mode <= 1'b0;
    kick(2);
    `CHK("ack", 1'b1, mii_mgmt_ack)
    u_vpan_mac_model.wr(8'hfc, 16'hffff);
    u_vpan_mac_model.rd(8'hfc, d);
    `CHK("unmapped", 16'h0000, d)
    $display("test access done");
    report_and_stop();
  end
endmodule : vpan_autoneg_tb
`undef CHK
`default_nettype wire
